// *** hdl/core_tick_timer.sv ***
`timescale 1ns/1ps
module core_tick_timer (
	input  wire logic                                ref_clk,
	input  wire logic                                rstn,
	input  wire logic                                countEnable,
	input  wire logic                                clearCurrent,
	input  wire logic [irq_map_pkg::TICK_WIDTH-1:0]  reloadValue,
	output logic      [irq_map_pkg::TICK_WIDTH-1:0]  currentValue,
	output logic                                     expired
);
	logic [irq_map_pkg::TICK_WIDTH-1:0] next_currentValue;
	logic                               next_expired;

	// down counter, reloads from zero, pulses as it reaches zero
	always_comb begin
		next_currentValue = currentValue;
		next_expired      = 1'b0;
		if (clearCurrent) begin
			next_currentValue = '0;
		end else if (countEnable) begin
			if (currentValue == '0) begin
				next_currentValue = reloadValue;
			end else begin
				next_currentValue = currentValue - 1'b1;
				next_expired      = (currentValue == {{(irq_map_pkg::TICK_WIDTH-1){1'b0}}, 1'b1});
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			currentValue <= '0;
			expired      <= 1'b0;
		end else begin
			currentValue <= next_currentValue;
			expired      <= next_expired;
		end
	end
endmodule

// *** hdl/interrupt_source_map.sv ***
`timescale 1ns/1ps
module interrupt_source_map (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        supplyLowFailIrq,
	input  wire logic        systemClockFailIrq,
	input  wire logic        crystalOscFailIrq,
	input  wire logic        watchdogIrq,
	input  wire logic [3:0]  timerLowIrq,
	input  wire logic        timer8Irq,
	input  wire logic        timer9Irq,
	input  wire logic        portAFirstIrq,
	input  wire logic        portASecondIrq,
	input  wire logic        portBFirstIrq,
	input  wire logic        portBSecondIrq,
	input  wire logic        portCFirstIrq,
	input  wire logic        portCSecondIrq,
	input  wire logic        portDFirstIrq,
	input  wire logic        portDSecondIrq,
	input  wire logic        motorPwmIrq,
	input  wire logic        motorPwmProtectIrq,
	input  wire logic        motorPwmOvervoltIrq,
	input  wire logic        spi0Irq,
	input  wire logic        i2c0Irq,
	input  wire logic        uart0Irq,
	input  wire logic        uart1Irq,
	input  wire logic        converter0Irq,
	input  wire logic        converter1Irq,
	output logic [63:0]      requestLines,
	output logic             irqOut,
	output logic             activeValid,
	output logic [5:0]       activeNum,
	output logic [31:0]      activeVector,
	output logic             tickException
);
	localparam int PB = irq_map_pkg::PRIORITY_BIT_COUNT;
	localparam int NREQ = irq_map_pkg::REQ_COUNT;

	logic [NREQ-1:0]         rawRequests;
	logic [NREQ-1:0]         status;
	logic [NREQ-1:0]         enable;
	logic [PB-1:0]           prio [NREQ];
	logic [NREQ*PB-1:0]      prioFlat;
	logic                    tickEnable;
	logic                    tickExcEnable;
	logic                    tickFlag;
	logic [23:0]             tickReload;
	logic [23:0]             tickCurrent;
	logic                    tickExpired;
	logic [6:0]              queryExc;
	logic                    arbValid;
	logic [5:0]              arbNum;

	logic [NREQ-1:0]         next_status;
	logic [NREQ-1:0]         next_enable;
	logic [PB-1:0]           next_prio [NREQ];
	logic                    next_tickEnable;
	logic                    next_tickExcEnable;
	logic                    next_tickFlag;
	logic [23:0]             next_tickReload;
	logic [6:0]              next_queryExc;
	logic [31:0]             next_prdata;
	logic                    next_pslverr;
	logic [NREQ-1:0]         next_requestLines;
	logic                    next_irqOut;
	logic                    next_activeValid;
	logic [5:0]              next_activeNum;
	logic [31:0]             next_activeVector;
	logic                    next_tickException;

	logic                    setupPhase;
	logic                    writeAccess;
	logic                    readAccess;
	logic                    tickClear;
	logic                    isPriorityArea;
	logic [NREQ-1:0]         pendingEnabled;
	logic [31:0]             queryVector;
	logic                    clearLoWrite;
	logic                    clearHiWrite;
	logic                    ctrlRead;

	// byte address of an exception number's word, four bytes per entry, table starts at zero
	function automatic logic [31:0] vectorAddr(input logic [6:0] exc);
		vectorAddr = 32'(exc) << irq_map_pkg::VECTOR_STRIDE_SHIFT;
	endfunction

	// true when an exception number has no handler word in use
	function automatic logic excReserved(input logic [6:0] exc);
		logic [6:0] extIdx;
		extIdx = exc - irq_map_pkg::FIRST_EXTERNAL_EXC;
		if (exc > irq_map_pkg::LAST_EXC) begin
			excReserved = 1'b1;
		end else if (exc < irq_map_pkg::FIRST_EXTERNAL_EXC) begin
			excReserved = irq_map_pkg::SYSTEM_RESERVED_MASK[exc[3:0]];
		end else begin
			excReserved = !irq_map_pkg::USED_REQ_MASK[extIdx[5:0]];
		end
	endfunction

	// source placement on the request vector
	always_comb begin
		rawRequests = '0;
		rawRequests[irq_map_pkg::REQ_SUPPLY_LOW]   = supplyLowFailIrq;
		rawRequests[irq_map_pkg::REQ_CLOCK_FAIL]   = systemClockFailIrq;
		rawRequests[irq_map_pkg::REQ_CRYSTAL_FAIL] = crystalOscFailIrq;
		rawRequests[irq_map_pkg::REQ_WATCHDOG]     = watchdogIrq;
		rawRequests[irq_map_pkg::REQ_TIMER0 +: 4]  = timerLowIrq;
		rawRequests[irq_map_pkg::REQ_TIMER8]       = timer8Irq;
		rawRequests[irq_map_pkg::REQ_TIMER9]       = timer9Irq;
		rawRequests[irq_map_pkg::REQ_PORT_FIRST +: 8] = {portDSecondIrq, portDFirstIrq,
			portCSecondIrq, portCFirstIrq, portBSecondIrq, portBFirstIrq,
			portASecondIrq, portAFirstIrq};
		rawRequests[irq_map_pkg::REQ_MOTOR_PWM]    = motorPwmIrq;
		rawRequests[irq_map_pkg::REQ_MOTOR_PROT]   = motorPwmProtectIrq;
		rawRequests[irq_map_pkg::REQ_MOTOR_OVV]    = motorPwmOvervoltIrq;
		rawRequests[irq_map_pkg::REQ_SPI0]         = spi0Irq;
		rawRequests[irq_map_pkg::REQ_I2C0]         = i2c0Irq;
		rawRequests[irq_map_pkg::REQ_UART0]        = uart0Irq;
		rawRequests[irq_map_pkg::REQ_UART1]        = uart1Irq;
		rawRequests[irq_map_pkg::REQ_CONVERTER0]   = converter0Irq;
		rawRequests[irq_map_pkg::REQ_CONVERTER1]   = converter1Irq;
	end

	generate
		for (genvar g = 0; g < NREQ; g++) begin : gen_flat
			assign prioFlat[g*PB +: PB] = prio[g];
		end
	endgenerate

	irq_priority_arbiter u_arbiter (
		.pendingMask  (pendingEnabled),
		.priorityFlat (prioFlat),
		.winnerValid  (arbValid),
		.winnerNum    (arbNum)
	);

	core_tick_timer u_tick (
		.ref_clk      (ref_clk),
		.rstn         (rstn),
		.countEnable  (tickEnable),
		.clearCurrent (tickClear),
		.reloadValue  (tickReload),
		.currentValue (tickCurrent),
		.expired      (tickExpired)
	);

	assign pready         = 1'b1;
	assign setupPhase     = psel && !penable;
	assign writeAccess    = psel && penable && pwrite;
	assign readAccess     = psel && penable && !pwrite;
	assign tickClear      = writeAccess && (paddr == irq_map_pkg::TICK_CURRENT);
	assign isPriorityArea = (paddr <= irq_map_pkg::PRIORITY_LAST) && (paddr[1:0] == 2'b00);
	assign pendingEnabled = status & enable;
	assign queryVector    = vectorAddr(queryExc);
	assign clearLoWrite   = writeAccess && (paddr == irq_map_pkg::CLEAR_LO);
	assign clearHiWrite   = writeAccess && (paddr == irq_map_pkg::CLEAR_HI);
	assign ctrlRead       = readAccess && (paddr == irq_map_pkg::TICK_CTRL);

	// register bus and configuration
	always_comb begin
		next_enable        = enable;
		next_prio          = prio;
		next_tickEnable    = tickEnable;
		next_tickExcEnable = tickExcEnable;
		next_tickReload    = tickReload;
		next_queryExc      = queryExc;
		next_prdata        = prdata;
		next_pslverr       = pslverr;

		// read data and error are prepared in the setup cycle
		if (setupPhase) begin
			next_prdata  = '0;
			next_pslverr = 1'b0;
			if (isPriorityArea) begin
				for (int k = 0; k < irq_map_pkg::BYTES_PER_WORD; k++) begin
					next_prdata[k*irq_map_pkg::PRIORITY_BYTE_WIDTH + irq_map_pkg::PRIORITY_FIELD_LSB +: PB] =
						prio[{paddr[5:2], 2'(k)}];
				end
			end else begin
				unique case (paddr)
					irq_map_pkg::STATUS_LO: next_prdata = status[31:0];
					irq_map_pkg::STATUS_HI: next_prdata = status[63:32];
					irq_map_pkg::ENABLE_LO: next_prdata = enable[31:0];
					irq_map_pkg::ENABLE_HI: next_prdata = enable[63:32];
					irq_map_pkg::CLEAR_LO,
					irq_map_pkg::CLEAR_HI: next_prdata = '0;
					irq_map_pkg::TICK_CTRL: begin
						next_prdata[irq_map_pkg::TICK_CTRL_ENABLE_BIT] = tickEnable;
						next_prdata[irq_map_pkg::TICK_CTRL_EXC_BIT]    = tickExcEnable;
						next_prdata[irq_map_pkg::TICK_CTRL_FLAG_BIT]   = tickFlag;
					end
					irq_map_pkg::TICK_RELOAD:  next_prdata = 32'(tickReload);
					irq_map_pkg::TICK_CURRENT: next_prdata = 32'(tickCurrent);
					irq_map_pkg::VECTOR_QUERY: begin
						next_prdata[6:0] = queryExc;
						next_prdata[irq_map_pkg::QUERY_RESERVED_BIT] = excReserved(queryExc);
						next_prdata[irq_map_pkg::QUERY_ADDR_LSB +: 16] = queryVector[15:0];
					end
					irq_map_pkg::ACTIVE_REQUEST: begin
						next_prdata[5:0] = activeNum;
						next_prdata[irq_map_pkg::ACTIVE_ADDR_LSB +: 12] = activeVector[11:0];
						next_prdata[irq_map_pkg::ACTIVE_VALID_BIT] = activeValid;
					end
					default: next_pslverr = 1'b1;
				endcase
			end
		end

		// writes take effect on the access edge only
		if (writeAccess) begin
			if (isPriorityArea) begin
				for (int k = 0; k < irq_map_pkg::BYTES_PER_WORD; k++) begin
					next_prio[{paddr[5:2], 2'(k)}] =
						pwdata[k*irq_map_pkg::PRIORITY_BYTE_WIDTH + irq_map_pkg::PRIORITY_FIELD_LSB +: PB];
				end
			end else begin
				unique case (paddr)
					irq_map_pkg::ENABLE_LO: next_enable[31:0]  = pwdata;
					irq_map_pkg::ENABLE_HI: next_enable[63:32] = pwdata;
					irq_map_pkg::TICK_CTRL: begin
						next_tickEnable    = pwdata[irq_map_pkg::TICK_CTRL_ENABLE_BIT];
						next_tickExcEnable = pwdata[irq_map_pkg::TICK_CTRL_EXC_BIT];
					end
					irq_map_pkg::TICK_RELOAD:  next_tickReload = pwdata[23:0];
					irq_map_pkg::VECTOR_QUERY: next_queryExc   = pwdata[6:0];
					default: ;
				endcase
			end
		end

	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			enable        <= '0;
			prio          <= '{default: '0};
			tickEnable    <= 1'b0;
			tickExcEnable <= 1'b0;
			tickReload    <= '0;
			queryExc      <= '0;
			prdata        <= '0;
			pslverr       <= 1'b0;
		end else begin
			enable        <= next_enable;
			prio          <= next_prio;
			tickEnable    <= next_tickEnable;
			tickExcEnable <= next_tickExcEnable;
			tickReload    <= next_tickReload;
			queryExc      <= next_queryExc;
			prdata        <= next_prdata;
			pslverr       <= next_pslverr;
		end
	end

	// sticky status, a request in the clear cycle wins
	always_comb begin
		next_status = status | requestLines;
		if (clearLoWrite) begin
			next_status[31:0] = (status[31:0] & ~pwdata) | requestLines[31:0];
		end
		if (clearHiWrite) begin
			next_status[63:32] = (status[63:32] & ~pwdata) | requestLines[63:32];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// reading the control word clears the flag, a new expiry wins
	always_comb begin
		next_tickFlag = tickFlag;
		if (ctrlRead) begin
			next_tickFlag = 1'b0;
		end
		if (tickExpired) begin
			next_tickFlag = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tickFlag <= 1'b0;
		end else begin
			tickFlag <= next_tickFlag;
		end
	end

	// per-cycle outputs toward the core
	always_comb begin
		next_requestLines  = rawRequests & irq_map_pkg::USED_REQ_MASK;
		next_irqOut        = |pendingEnabled;
		next_activeValid   = arbValid;
		next_activeNum     = arbNum;
		next_activeVector  = vectorAddr(irq_map_pkg::FIRST_EXTERNAL_EXC + 7'(arbNum));
		next_tickException = tickExpired && tickExcEnable;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			requestLines  <= '0;
			irqOut        <= 1'b0;
			activeValid   <= 1'b0;
			activeNum     <= '0;
			activeVector  <= '0;
			tickException <= 1'b0;
		end else begin
			requestLines  <= next_requestLines;
			irqOut        <= next_irqOut;
			activeValid   <= next_activeValid;
			activeNum     <= next_activeNum;
			activeVector  <= next_activeVector;
			tickException <= next_tickException;
		end
	end
endmodule

// *** hdl/irq_priority_arbiter.sv ***
`timescale 1ns/1ps
module irq_priority_arbiter (
	input  wire logic [irq_map_pkg::REQ_COUNT-1:0]                                   pendingMask,
	input  wire logic [irq_map_pkg::REQ_COUNT*irq_map_pkg::PRIORITY_BIT_COUNT-1:0]   priorityFlat,
	output logic                                                                     winnerValid,
	output logic      [irq_map_pkg::REQ_INDEX_WIDTH-1:0]                             winnerNum
);
	logic [irq_map_pkg::PRIORITY_BIT_COUNT-1:0] bestPrio;
	logic [irq_map_pkg::PRIORITY_BIT_COUNT-1:0] candPrio;

	// lowest priority value wins, ties go to the lower request number
	always_comb begin
		winnerValid = 1'b0;
		winnerNum   = '0;
		bestPrio    = '1;
		candPrio    = '0;
		for (int n = irq_map_pkg::REQ_COUNT - 1; n >= 0; n--) begin
			candPrio = priorityFlat[n*irq_map_pkg::PRIORITY_BIT_COUNT +: irq_map_pkg::PRIORITY_BIT_COUNT];
			if (pendingMask[n] && (!winnerValid || candPrio <= bestPrio)) begin
				winnerValid = 1'b1;
				winnerNum   = n[irq_map_pkg::REQ_INDEX_WIDTH-1:0];
				bestPrio    = candPrio;
			end
		end
	end
endmodule

// *** shared/irq_map_pkg.sv ***
package irq_map_pkg;

	localparam int REQ_COUNT          = 64;
	localparam int REQ_INDEX_WIDTH    = 6;
	localparam int PRIORITY_BIT_COUNT = 3;
	localparam int PRIORITY_BYTE_WIDTH = 8;
	localparam int PRIORITY_FIELD_LSB = PRIORITY_BYTE_WIDTH - PRIORITY_BIT_COUNT;
	localparam int BYTES_PER_WORD     = 4;
	localparam int ADDR_WIDTH         = 12;
	localparam int DATA_WIDTH         = 32;
	localparam int TICK_WIDTH         = 24;
	localparam int EXC_WIDTH          = 7;
	localparam int VECTOR_STRIDE_SHIFT = 2;

	// register offsets
	localparam logic [ADDR_WIDTH-1:0] PRIORITY_LAST  = 12'h03c;
	localparam logic [ADDR_WIDTH-1:0] STATUS_LO      = 12'h040;
	localparam logic [ADDR_WIDTH-1:0] STATUS_HI      = 12'h044;
	localparam logic [ADDR_WIDTH-1:0] ENABLE_LO      = 12'h048;
	localparam logic [ADDR_WIDTH-1:0] ENABLE_HI      = 12'h04c;
	localparam logic [ADDR_WIDTH-1:0] CLEAR_LO       = 12'h050;
	localparam logic [ADDR_WIDTH-1:0] CLEAR_HI       = 12'h054;
	localparam logic [ADDR_WIDTH-1:0] TICK_CTRL      = 12'h058;
	localparam logic [ADDR_WIDTH-1:0] TICK_RELOAD    = 12'h05c;
	localparam logic [ADDR_WIDTH-1:0] TICK_CURRENT   = 12'h060;
	localparam logic [ADDR_WIDTH-1:0] VECTOR_QUERY   = 12'h064;
	localparam logic [ADDR_WIDTH-1:0] ACTIVE_REQUEST = 12'h068;

	// field positions
	localparam int TICK_CTRL_ENABLE_BIT = 0;
	localparam int TICK_CTRL_EXC_BIT    = 1;
	localparam int TICK_CTRL_FLAG_BIT   = 16;
	localparam int QUERY_RESERVED_BIT   = 7;
	localparam int QUERY_ADDR_LSB       = 16;
	localparam int ACTIVE_ADDR_LSB      = 16;
	localparam int ACTIVE_VALID_BIT     = 31;

	// exception map
	localparam logic [EXC_WIDTH-1:0] FIRST_EXTERNAL_EXC = 7'h10;
	localparam logic [EXC_WIDTH-1:0] LAST_EXC           = 7'h4f;
	localparam logic [15:0]          SYSTEM_RESERVED_MASK = 16'h4f80;
	localparam logic [REQ_COUNT-1:0] USED_REQ_MASK = 64'h0000_18d1_07ff_61ef;

	// request numbers of the sources
	localparam int REQ_SUPPLY_LOW   = 0;
	localparam int REQ_CLOCK_FAIL   = 1;
	localparam int REQ_CRYSTAL_FAIL = 2;
	localparam int REQ_WATCHDOG     = 3;
	localparam int REQ_TIMER0       = 5;
	localparam int REQ_TIMER8       = 13;
	localparam int REQ_TIMER9       = 14;
	localparam int REQ_PORT_FIRST   = 16;
	localparam int REQ_MOTOR_PWM    = 24;
	localparam int REQ_MOTOR_PROT   = 25;
	localparam int REQ_MOTOR_OVV    = 26;
	localparam int REQ_SPI0         = 32;
	localparam int REQ_I2C0         = 36;
	localparam int REQ_UART0        = 38;
	localparam int REQ_UART1        = 39;
	localparam int REQ_CONVERTER0   = 43;
	localparam int REQ_CONVERTER1   = 44;

endpackage

// *** tb/core_vector_model.sv ***
`timescale 1ns/1ps
module core_vector_model (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        irqOut,
	input  wire logic        activeValid,
	input  wire logic [31:0] activeVector,
	output logic      [31:0] takenVector
);
	// core side: latches the vector word it would fetch while the request line stands
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			takenVector <= 32'h0;
		end else if (irqOut && activeValid) begin
			takenVector <= activeVector;
		end
	end
endmodule

// *** tb/interrupt_source_map_props.sv ***
`timescale 1ns/1ps
module interrupt_source_map_props (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic [11:0] paddr,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        supplyLowFailIrq,
	input wire logic        watchdogIrq,
	input wire logic [3:0]  timerLowIrq,
	input wire logic        portAFirstIrq,
	input wire logic        portDSecondIrq,
	input wire logic        motorPwmOvervoltIrq,
	input wire logic        spi0Irq,
	input wire logic        converter1Irq,
	input wire logic [63:0] requestLines,
	input wire logic        irqOut,
	input wire logic        activeValid,
	input wire logic [5:0]  activeNum,
	input wire logic [31:0] activeVector,
	input wire logic        tickException
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	reserved_lines_a: assert property ((requestLines & ~irq_map_pkg::USED_REQ_MASK) == 64'h0)
		else $error("reserved request line active");
	supply_lines_a: assert property (requestLines[0] == $past(supplyLowFailIrq)
		&& requestLines[3] == $past(watchdogIrq))
		else $error("supply or watchdog line misplaced");
	timer_lines_a: assert property (requestLines[8:5] == $past(timerLowIrq))
		else $error("timer lines misplaced");
	port_lines_a: assert property (requestLines[16] == $past(portAFirstIrq)
		&& requestLines[23] == $past(portDSecondIrq))
		else $error("port lines misplaced");
	motor_line_a: assert property ($rose(motorPwmOvervoltIrq) |=> requestLines[26])
		else $error("overvolt line misplaced");
	serial_line_a: assert property (spi0Irq |=> requestLines[32])
		else $error("serial line misplaced");
	converter_line_a: assert property (converter1Irq |=> requestLines[44] && !requestLines[45])
		else $error("converter line misplaced");
	vector_addr_a: assert property (activeValid |-> activeVector == 32'h40 + {24'h0, activeNum, 2'b00})
		else $error("vector address wrong");
	apb_ready_a: assert property (psel && penable && paddr <= irq_map_pkg::PRIORITY_LAST
		&& paddr[1:0] == 2'b00 |-> pready && !pslverr)
		else $error("aligned priority access refused");
	tick_pulse_a: assert property (tickException |=> !tickException)
		else $error("tick pulse too long");
	irq_seen_c: cover property ($rose(irqOut));
	tick_seen_c: cover property (tickException);
	refuse_seen_c: cover property (psel && penable && pslverr);
endmodule
bind interrupt_source_map interrupt_source_map_props chk (.ref_clk, .rstn, .psel, .penable, .pready, .pslverr,
	.supplyLowFailIrq, .watchdogIrq, .timerLowIrq, .portAFirstIrq, .portDSecondIrq, .motorPwmOvervoltIrq,
	.spi0Irq, .converter1Irq, .requestLines, .irqOut, .activeValid, .activeNum, .activeVector, .tickException,
	.paddr);

// *** tb/interrupt_source_map_tb.sv ***
`timescale 1ns/1ps
module interrupt_source_map_tb;
	logic        ref_clk;
	logic        rstn;
	logic [11:0] paddr;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] pwdata, prdata, rd, lo, activeVector, takenVector;
	logic        irqOut, activeValid, tickException;
	logic [5:0]  activeNum;
	logic [63:0] requestLines;
	logic [26:0] src;
	int          bad_count, compares, n;
	int          reqOf [27] = '{0, 1, 2, 3, 5, 6, 7, 8, 13, 14, 16, 17, 18, 19, 20, 21, 22, 23,
	                            24, 25, 26, 32, 36, 38, 39, 43, 44};
	int          excOf [12] = '{0, 1, 6, 7, 11, 12, 14, 15, 16, 20, 79, 80};

	interrupt_source_map uut (.ref_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .supplyLowFailIrq(src[0]), .systemClockFailIrq(src[1]), .crystalOscFailIrq(src[2]),
		.watchdogIrq(src[3]), .timerLowIrq(src[7:4]), .timer8Irq(src[8]), .timer9Irq(src[9]),
		.portAFirstIrq(src[10]), .portASecondIrq(src[11]), .portBFirstIrq(src[12]), .portBSecondIrq(src[13]),
		.portCFirstIrq(src[14]), .portCSecondIrq(src[15]), .portDFirstIrq(src[16]), .portDSecondIrq(src[17]),
		.motorPwmIrq(src[18]), .motorPwmProtectIrq(src[19]), .motorPwmOvervoltIrq(src[20]), .spi0Irq(src[21]),
		.i2c0Irq(src[22]), .uart0Irq(src[23]), .uart1Irq(src[24]), .converter0Irq(src[25]),
		.converter1Irq(src[26]), .requestLines, .irqOut, .activeValid, .activeNum, .activeVector, .tickException);

	core_vector_model core (.ref_clk, .rstn, .irqOut, .activeValid, .activeVector, .takenVector);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic finish_test;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		if (k >= 20) begin
			bad_count++;
			finish_test;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wait_tick(output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (tickException !== 1'b1 && c < 100);
		if (c >= 100) begin
			bad_count++;
			finish_test;
		end
	endtask

	function automatic logic [31:0] qexp(input int e);
		logic r;
		r = (e >= 7 && e <= 11) || e == 14 || e > 79;
		if (e >= 16 && e <= 79) r = !irq_map_pkg::USED_REQ_MASK[e-16];
		return {16'(4 * e), 8'h00, r, 7'(e)};
	endfunction

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		src = 27'h0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		// priority words: only the top three bits of each byte hold
		apb(1'b1, 12'h004, 32'hffffffff);
		apb(1'b1, 12'h008, 32'h20406080);
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'he0e0e0e0);
		apb(1'b0, 12'h008, 32'h0);
		check(rd, 32'h20406080);
		apb(1'b0, 12'h006, 32'h0);
		check(err, 1'b1);
		// vector table layout queries
		foreach (excOf[i]) begin
			apb(1'b1, irq_map_pkg::VECTOR_QUERY, 32'(excOf[i]));
			apb(1'b0, irq_map_pkg::VECTOR_QUERY, 32'h0);
			check(rd, qexp(excOf[i]));
		end
		// each source on its own request line
		apb(1'b1, irq_map_pkg::ENABLE_LO, 32'hffffffff);
		apb(1'b1, irq_map_pkg::ENABLE_HI, 32'hffffffff);
		foreach (reqOf[i]) begin
			src <= 27'h1 << i;
			repeat (4) @(posedge ref_clk);
			check(requestLines, 64'h1 << reqOf[i]);
			check({irqOut, activeValid, activeNum, activeVector}, {2'b11, 6'(reqOf[i]), 32'(64 + 4 * reqOf[i])});
			@(posedge ref_clk);
			check(takenVector, 32'(64 + 4 * reqOf[i]));
			apb(1'b0, irq_map_pkg::STATUS_LO, 32'h0);
			lo = rd;
			apb(1'b0, irq_map_pkg::STATUS_HI, 32'h0);
			check({rd, lo}, 64'h1 << reqOf[i]);
			src <= 27'h0;
			apb(1'b1, irq_map_pkg::CLEAR_LO, 32'hffffffff);
			apb(1'b1, irq_map_pkg::CLEAR_HI, 32'hffffffff);
		end
		// masking, then priority value beats request number
		apb(1'b1, irq_map_pkg::ENABLE_LO, 32'h0);
		apb(1'b1, irq_map_pkg::ENABLE_HI, 32'h0);
		apb(1'b1, 12'h000, 32'h4000a000);
		src <= 27'h000000a;
		repeat (4) @(posedge ref_clk);
		check(irqOut, 1'b0);
		apb(1'b0, irq_map_pkg::STATUS_LO, 32'h0);
		check(rd, 32'h0000000a);
		apb(1'b0, irq_map_pkg::CLEAR_LO, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, irq_map_pkg::ENABLE_LO, 32'h0000000f);
		repeat (3) @(posedge ref_clk);
		check({irqOut, activeNum}, {1'b1, 6'h03});
		apb(1'b0, irq_map_pkg::ACTIVE_REQUEST, 32'h0);
		check(rd, 32'h804c0003);
		apb(1'b0, irq_map_pkg::ENABLE_LO, 32'h0);
		check(rd, 32'h0000000f);
		src <= 27'h0;
		apb(1'b1, irq_map_pkg::CLEAR_LO, 32'h0000000a);
		repeat (3) @(posedge ref_clk);
		check({irqOut, activeValid}, 2'b00);
		// tick timer width and period
		apb(1'b1, irq_map_pkg::TICK_RELOAD, 32'hffffffff);
		apb(1'b0, irq_map_pkg::TICK_RELOAD, 32'h0);
		check(rd, 32'h00ffffff);
		apb(1'b1, irq_map_pkg::TICK_RELOAD, 32'h00000005);
		apb(1'b1, irq_map_pkg::TICK_CTRL, 32'h00000003);
		wait_tick(n);
		wait_tick(n);
		check(n, 6);
		apb(1'b1, irq_map_pkg::TICK_CTRL, 32'h00000002);
		apb(1'b0, irq_map_pkg::TICK_CTRL, 32'h0);
		check(rd, 32'h00010002);
		apb(1'b0, irq_map_pkg::TICK_CTRL, 32'h0);
		check(rd, 32'h00000002);
		apb(1'b0, irq_map_pkg::TICK_CURRENT, 32'h0);
		check(rd, 32'h00000002);
		apb(1'b1, irq_map_pkg::TICK_CURRENT, 32'h0);
		apb(1'b0, irq_map_pkg::TICK_CURRENT, 32'h0);
		check(rd, 32'h0);
		finish_test;
	end
endmodule
